// ### core/bcrc_cfg.svh
// Offsets, field positions, reset values and cycle counts for the
// clock and reset control block. Included by the package and the core.
`ifndef BCRC_CFG_SVH
`define BCRC_CFG_SVH
// Register byte offsets
`define BCRC_CTRL_OFS 8'h00
`define BCRC_MASK_OFS 8'h04
`define BCRC_STAT_OFS 8'h08
// Reset values and power state codes
`define BCRC_MASK_RST 16'h0000
`define BCRC_PM_D0 2'h0
`define BCRC_PM_D3HOT 2'h3
// Synchronised pin vector positions
`define BCRC_IN_PRST 0
`define BCRC_IN_STABLE 1
`define BCRC_IN_OSC 2
`define BCRC_IN_PCLK 3
`define BCRC_IN_MASK 4
`define BCRC_IN_PFAST 5
`define BCRC_IN_SFAST 6
`define BCRC_IN_STRAP 7
`define BCRC_IN_OSCSEL 8
`define BCRC_IN_W 9
// Cycle counts
`define BCRC_SEC_REL_CYC 6'h2B
`define BCRC_INIT_CYC 6'h20
`define BCRC_SHIFT_LAST 5'h0F
`define BCRC_CHIP_RST_CYC 2'h3
`define BCRC_CHIP_CLR_CYC 2'h1
`endif

// ### core/bcrc_pkg.sv
// Types for the clock and reset control block.
// Assumes bcrc_cfg.svh is on the include path.
package bcrc_pkg;
`include "bcrc_cfg.svh"

typedef enum logic [3:0] {
   BCRC_SEQ_HOLD = 4'h1,
   BCRC_SEQ_SHIFT = 4'h2,
   BCRC_SEQ_WAIT = 4'h4,
   BCRC_SEQ_RUN = 4'h8
} bcrc_seq_type;

typedef struct packed {
   logic direct;
   logic [1:0] pm;
   logic chip_rst;
   logic sec_rst;
} bcrc_ctrl_type;

typedef struct packed {
   logic [`BCRC_IN_W-1:0] s1;
   logic [`BCRC_IN_W-1:0] s2;
   logic [`BCRC_IN_W-1:0] s3;
   logic [`BCRC_IN_W-1:0] f;
   bcrc_seq_type seq;
   logic [5:0] rel_cnt;
   logic [5:0] init_cnt;
   logic rdy;
   logic [1:0] chip_cnt;
   logic chip_busy;
   logic phase;
   logic [4:0] bit_idx;
   logic [15:0] shreg;
   logic [15:0] mask;
   bcrc_ctrl_type ctrl;
   logic pm_pulse;
   logic src_q;
   logic half;
   logic clk;
   logic sec_n;
   logic flush;
   logic load_n;
   logic strobe;
   logic [31:0] prdata;
} bcrc_state_type;
endpackage

// ### core/bcrc_top.sv
// Clock source selection, secondary clock division and reset sequencing.
// Assumes an APB master on pclk and asynchronous board pins.
//
// Overview of operation
// - With oscillator select low, secondary clocks come from the oscillator input.
// - Oscillator-derived clocks still get the division chosen by the fast enables.
// - Clock-stable low keeps the secondary reset output asserted.
// - Divide by two only when primary fast is high and secondary fast low.
// - Primary fast low makes the block drive secondary fast low.
// - Fast strap high sets fast-capable bits in both status views.
// - A directly fed external secondary clock bypasses the division.
// - After any reset release, 32 clocks of initialisation precede bridge operation.
// - Primary outputs float within one clock of primary reset assertion.
// - Primary reset resets secondary; output released 43 clocks after release.
// - Clock mask shifting starts at the primary reset rising edge.
// - Secondary reset held during primary reset and the mask shift.
// - Asynchronous primary reset edges accepted; internal reset done in 32 clocks.
// - Primary reset clears all posted and delayed transaction buffers.
// - Software secondary reset bit holds the secondary reset output until cleared.
// - Chip reset clears registers and state, without secondary reset or floating.
// - Chip reset bit self-clears within 4 clocks after its write.
// - No access is answered while a chip reset runs.
// - Power state D3hot to D0 gives internal reset without secondary reset.
// - Mask shift takes 16 cycles, 32 at fast rate; release waits for it.
`timescale 1ns/10ps
`include "bcrc_cfg.svh"
module bcrc_top
   import bcrc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pri_reset_in_n,
   input wire logic sec_clock_stable,
   input wire logic ext_osc_select_n,
   input wire logic ext_osc_clock,
   input wire logic pri_clock_in,
   input wire logic pri_fast_bus_enable,
   input wire logic sec_fast_bus_enable,
   output logic sec_fast_bus_enable_out,
   output logic sec_fast_bus_enable_oe,
   input wire logic fast_capable_strap,
   input wire logic mask_serial_in,
   output logic mask_shift_load_n,
   output logic mask_shift_strobe,
   output logic [9:0] sec_clock_out,
   output logic [9:0] sec_clock_oe,
   output logic sec_reset_out_n,
   output logic pri_out_float,
   output logic buffer_clear,
   output logic bridge_ready
);

////////////////////////////////////////////////////////////////////////
// Helpers

// Clock enables from the shifted mask: outputs 0-3 take slot pairs, enabled if either bit is low; outputs 4-9 take one bit each
function automatic logic [9:0] mask_to_en(input logic [15:0] m);
   logic [9:0] e;
   e = 10'h000;
   for (int i = 0; i < 4; i++) begin
      e[i] = ~(m[2*i] & m[2*i+1]);
   end
   for (int i = 4; i < 10; i++) begin
      e[i] = ~m[i+4];
   end
   return e;
endfunction

function automatic logic [31:0] read_word(input bcrc_state_type s, input logic [7:0] a);
   logic [31:0] d;
   d = 32'h0000_0000;
   unique case (a)
      `BCRC_CTRL_OFS: d[4:0] = s.ctrl;
      `BCRC_MASK_OFS: d[15:0] = s.mask;
      `BCRC_STAT_OFS: begin
         d[0] = s.f[`BCRC_IN_STRAP];
         d[1] = s.f[`BCRC_IN_STRAP];
         d[2] = ~s.sec_n;
         d[3] = s.rdy;
         d[4] = s.f[`BCRC_IN_PFAST] & ~s.f[`BCRC_IN_SFAST] & ~s.ctrl.direct;
         d[5] = (s.seq == BCRC_SEQ_SHIFT);
         d[6] = s.f[`BCRC_IN_STABLE];
      end
      default: d = 32'h0000_0000;
   endcase
   return d;
endfunction

function automatic logic is_mapped(input logic [7:0] a);
   return (a == `BCRC_CTRL_OFS) || (a == `BCRC_MASK_OFS) || (a == `BCRC_STAT_OFS);
endfunction

////////////////////////////////////////////////////////////////////////
// State

bcrc_state_type st_ff;
bcrc_state_type nxt_st;
logic [`BCRC_IN_W-1:0] pins;
logic wr_acc;
logic prst_ok;
logic fast;
logic take;
logic src;
logic rise;
logic div2;
bcrc_ctrl_type wctrl;

assign pins = {ext_osc_select_n, fast_capable_strap, sec_fast_bus_enable, pri_fast_bus_enable,
               mask_serial_in, pri_clock_in, ext_osc_clock, sec_clock_stable, pri_reset_in_n};
assign pready = ~st_ff.chip_busy;
assign pslverr = psel & penable & ~is_mapped(paddr);
assign wr_acc = psel & penable & pready & pwrite;
assign wctrl = bcrc_ctrl_type'(pwdata[4:0]);
assign prst_ok = st_ff.f[`BCRC_IN_PRST];
assign fast = st_ff.f[`BCRC_IN_PFAST];
assign take = (st_ff.seq == BCRC_SEQ_SHIFT) & (~fast | st_ff.phase);
assign src = st_ff.f[`BCRC_IN_OSCSEL] ? st_ff.f[`BCRC_IN_PCLK] : st_ff.f[`BCRC_IN_OSC];
assign rise = src & ~st_ff.src_q;
assign div2 = st_ff.f[`BCRC_IN_PFAST] & ~st_ff.f[`BCRC_IN_SFAST] & ~st_ff.ctrl.direct;

always_comb begin
   nxt_st = st_ff;
   // Pin synchronisers: a change counts once stages two and three agree
   nxt_st.s1 = pins;
   nxt_st.s2 = st_ff.s1;
   nxt_st.s3 = st_ff.s2;
   nxt_st.f = (st_ff.s2 & st_ff.s3) | (st_ff.f & (st_ff.s2 ^ st_ff.s3));
   nxt_st.pm_pulse = 1'h0;

   // Secondary clock generation
   nxt_st.src_q = src;
   if (rise) begin
      nxt_st.half = ~st_ff.half;
   end
   nxt_st.clk = div2 ? nxt_st.half : src;

   // Reset sequence
   nxt_st.strobe = take;
   unique case (st_ff.seq)
      BCRC_SEQ_HOLD: begin
         nxt_st.load_n = 1'h0;
         nxt_st.rel_cnt = 6'h00;
         nxt_st.bit_idx = 5'h00;
         nxt_st.phase = 1'h0;
         if (prst_ok) begin
            nxt_st.seq = BCRC_SEQ_SHIFT;
            nxt_st.load_n = 1'h1;
         end
      end
      BCRC_SEQ_SHIFT: begin
         nxt_st.phase = ~st_ff.phase;
         if (take) begin
            nxt_st.shreg = {st_ff.f[`BCRC_IN_MASK], st_ff.shreg[15:1]};
            nxt_st.bit_idx = st_ff.bit_idx + 5'h01;
            if (st_ff.bit_idx == `BCRC_SHIFT_LAST) begin
               nxt_st.mask = {st_ff.f[`BCRC_IN_MASK], st_ff.shreg[15:1]};
               nxt_st.seq = BCRC_SEQ_WAIT;
            end
         end
      end
      BCRC_SEQ_WAIT: begin
         if (st_ff.rel_cnt == `BCRC_SEC_REL_CYC) begin
            nxt_st.seq = BCRC_SEQ_RUN;
         end
      end
      BCRC_SEQ_RUN: begin
         nxt_st.seq = BCRC_SEQ_RUN;
      end
      default: nxt_st.seq = BCRC_SEQ_HOLD;
   endcase
   if (st_ff.seq != BCRC_SEQ_HOLD && st_ff.rel_cnt != `BCRC_SEC_REL_CYC) begin
      nxt_st.rel_cnt = st_ff.rel_cnt + 6'h01;
   end
   if (!prst_ok) begin
      nxt_st.seq = BCRC_SEQ_HOLD;
      nxt_st.load_n = 1'h0;
   end

   // Register writes
   if (wr_acc && paddr == `BCRC_MASK_OFS) begin
      nxt_st.mask = pwdata[15:0];
   end
   if (wr_acc && paddr == `BCRC_CTRL_OFS) begin
      nxt_st.ctrl = wctrl;
      if (st_ff.ctrl.pm == `BCRC_PM_D3HOT && wctrl.pm == `BCRC_PM_D0) begin
         nxt_st.pm_pulse = 1'h1;
      end
      if (wctrl.chip_rst) begin
         nxt_st.ctrl = bcrc_ctrl_type'(5'h02);
         nxt_st.mask = `BCRC_MASK_RST;
         nxt_st.chip_busy = 1'h1;
         nxt_st.chip_cnt = 2'h0;
      end
   end
   if (st_ff.chip_busy) begin
      nxt_st.chip_cnt = st_ff.chip_cnt + 2'h1;
      // Bit clears a cycle before access returns, so the first read sees it low
      if (st_ff.chip_cnt == `BCRC_CHIP_CLR_CYC) begin
         nxt_st.ctrl.chip_rst = 1'h0;
      end
      if (st_ff.chip_cnt == `BCRC_CHIP_RST_CYC - 2'h1) begin
         nxt_st.chip_busy = 1'h0;
      end
   end

   // Internal initialisation after any reset
   if (!prst_ok || st_ff.chip_busy || st_ff.pm_pulse) begin
      nxt_st.init_cnt = 6'h00;
   end else if (st_ff.init_cnt != `BCRC_INIT_CYC) begin
      nxt_st.init_cnt = st_ff.init_cnt + 6'h01;
   end
   nxt_st.rdy = (nxt_st.init_cnt == `BCRC_INIT_CYC);
   nxt_st.flush = ~prst_ok | st_ff.pm_pulse | st_ff.chip_busy;

   // Secondary reset output: all holding conditions must be false
   nxt_st.sec_n = (nxt_st.seq == BCRC_SEQ_RUN) & st_ff.f[`BCRC_IN_STABLE]
                  & ~nxt_st.ctrl.sec_rst;

   // Read data follows the registers until the access is taken
   if (psel && !(penable && pready)) begin
      nxt_st.prdata = read_word(st_ff, paddr);
   end
end

always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      st_ff <= '{seq: BCRC_SEQ_HOLD, mask: `BCRC_MASK_RST, load_n: 1'h0, default: '0};
   end else begin
      st_ff <= nxt_st;
   end
end

////////////////////////////////////////////////////////////////////////
// Outputs

assign prdata = st_ff.prdata;
assign sec_clock_out = {10{st_ff.clk}};
assign sec_clock_oe = mask_to_en(st_ff.mask);
assign sec_fast_bus_enable_out = 1'h0;
assign sec_fast_bus_enable_oe = ~st_ff.f[`BCRC_IN_PFAST];
assign sec_reset_out_n = st_ff.sec_n;
assign pri_out_float = ~pri_reset_in_n | ~prst_ok;
assign buffer_clear = st_ff.flush;
assign bridge_ready = st_ff.rdy;
assign mask_shift_load_n = st_ff.load_n;
assign mask_shift_strobe = st_ff.strobe;

////////////////////////////////////////////////////////////////////////
// Checks

default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

sequence chip_start_s;
   $rose(st_ff.chip_busy);
endsequence
sequence chip_end_s;
   ##[1:4] !st_ff.ctrl.chip_rst;
endsequence

unstable_hold_a: assert property (!st_ff.f[`BCRC_IN_STABLE] |=> !sec_reset_out_n)
   else $error("secondary reset released with clock unstable");
float_now_a: assert property (!pri_reset_in_n |-> pri_out_float)
   else $error("primary outputs not floating in reset");
release_43_a: assert property ($rose(sec_reset_out_n) |-> st_ff.rel_cnt == `BCRC_SEC_REL_CYC)
   else $error("secondary reset released before count");
shift_hold_a: assert property ((st_ff.seq == BCRC_SEQ_SHIFT) |=> !sec_reset_out_n)
   else $error("secondary reset released during shift");
shift_len_a: assert property ($fell(st_ff.seq == BCRC_SEQ_SHIFT) && prst_ok
   |-> st_ff.rel_cnt == (fast ? 6'h20 : 6'h10))
   else $error("mask shift length wrong");
chip_clear_a: assert property (chip_start_s |-> chip_end_s)
   else $error("chip reset bit not cleared in time");
chip_quiet_a: assert property (st_ff.chip_busy && prst_ok |-> !pready ##0 $stable(sec_reset_out_n))
   else $error("chip reset answered or moved secondary reset");
sw_hold_a: assert property (st_ff.ctrl.sec_rst |-> !sec_reset_out_n)
   else $error("software secondary reset not held");
pm_reset_a: assert property (st_ff.pm_pulse |=> buffer_clear && !bridge_ready)
   else $error("power state reset not applied");
slow_drive_a: assert property (!fast |-> sec_fast_bus_enable_oe && !sec_fast_bus_enable_out)
   else $error("secondary fast enable not driven low");
ready_init_a: assert property ($rose(bridge_ready) |-> $past(st_ff.init_cnt) == 6'h1F)
   else $error("bridge ready without full init");
divide_a: assert property (div2 && $past(div2) && rise |=> st_ff.clk != $past(st_ff.clk))
   else $error("divided clock did not toggle");

////////////////////////////////////////////////////////////////////////
// Sequencer, clock, chip reset and bus checks

// Shift register held in load while reset is seen
load_hold_a: assert property (!prst_ok
   |=> !mask_shift_load_n)
   else $error("mask shift register not loading in reset");
// Shifting only with the register in shift mode
shift_load_a: assert property ((st_ff.seq == BCRC_SEQ_SHIFT)
   |-> mask_shift_load_n)
   else $error("mask shift while load asserted");
// Buffers cleared while reset is seen
flush_prst_a: assert property (!prst_ok
   |=> buffer_clear)
   else $error("buffers not cleared in reset");
// Bridge not ready while reset is seen
ready_hold_a: assert property (!prst_ok
   |=> !bridge_ready)
   else $error("bridge ready during reset");
// Chip reset never floats the primary outputs
chip_nofloat_a: assert property (st_ff.chip_busy && pri_reset_in_n && prst_ok
   |-> !pri_out_float)
   else $error("chip reset floated primary outputs");
// Chip reset restores the mask
chip_mask_a: assert property ($rose(st_ff.chip_busy)
   |-> st_ff.mask == `BCRC_MASK_RST)
   else $error("chip reset left mask set");
// Undivided clock follows the selected source
undiv_clock_a: assert property (!div2
   |=> st_ff.clk == $past(src))
   else $error("undivided clock does not follow source");
// Release only when every hold is gone
release_path_a: assert property ($rose(sec_reset_out_n)
   |-> $past(st_ff.f[`BCRC_IN_STABLE]) && !st_ff.ctrl.sec_rst && st_ff.seq == BCRC_SEQ_RUN)
   else $error("secondary reset released with a hold active");
// Power state reset leaves the secondary reset alone
pm_no_srst_a: assert property (st_ff.pm_pulse && sec_reset_out_n && st_ff.f[`BCRC_IN_STABLE] && prst_ok && !wr_acc
   |=> sec_reset_out_n)
   else $error("power state reset asserted secondary reset");
// Strobes come only from the shift state
strobe_shift_a: assert property (mask_shift_strobe
   |-> $past(st_ff.seq == BCRC_SEQ_SHIFT))
   else $error("mask strobe outside shift");
// Error response only in an access phase
slverr_map_a: assert property (pslverr
   |-> psel && penable)
   else $error("slave error outside access");
// Chip reset count stays in range
chip_count_a: assert property (st_ff.chip_busy
   |-> st_ff.chip_cnt != `BCRC_CHIP_RST_CYC)
   else $error("chip reset count overran");
// Initialisation counts one per clock
init_count_a: assert property (!bridge_ready && prst_ok && !st_ff.chip_busy && !st_ff.pm_pulse
   |=> st_ff.init_cnt == $past(st_ff.init_cnt) + 6'h01)
   else $error("initialisation count stalled");
// Running state only after the full release count
rel_stop_a: assert property ((st_ff.seq == BCRC_SEQ_RUN)
   |-> st_ff.rel_cnt == `BCRC_SEC_REL_CYC)
   else $error("running before release count");
// Reset sends the sequencer back to hold
hold_enter_a: assert property (!prst_ok
   |=> st_ff.seq == BCRC_SEQ_HOLD)
   else $error("sequencer not held in reset");
// Outputs float while the synchronised reset is low
float_sync_a: assert property (!prst_ok
   |-> pri_out_float)
   else $error("outputs not floating during synced reset");
// Access answered once chip reset ends
pready_chip_a: assert property ($fell(st_ff.chip_busy)
   |-> pready)
   else $error("access not answered after chip reset");
// Chip reset write starts the busy period
chip_start_a: assert property (wr_acc && paddr == `BCRC_CTRL_OFS && wctrl.chip_rst
   |=> st_ff.chip_busy && st_ff.ctrl.chip_rst)
   else $error("chip reset write did not start reset");

endmodule

// ### dv/bcrc_board.sv
// Board model: clock sources and the external mask shift register.
// Assumes load/shift and strobe come from the block's mask pins.
`timescale 1ns/10ps
module bcrc_board (
   input wire logic pclk,
   input wire logic load_n,
   input wire logic strobe,
   output logic ser,
   output logic pri_clk,
   output logic osc_clk
);
   logic [15:0] sh;
   logic [2:0] dv;
   initial begin
      sh = 16'h0000;
      dv = 3'h0;
   end
   assign ser = sh[0];
   // Sources slow enough for the pin filters to follow
   assign pri_clk = dv[1];
   assign osc_clk = dv[2];
   always @(posedge pclk) begin
      dv <= dv + 3'h1;
      // Every slot reads absent, so the whole mask ends up set
      if (!load_n) begin
         sh <= 16'hFFFF;
      end else if (strobe) begin
         sh <= {1'b1, sh[15:1]};
      end
   end
endmodule

// ### dv/tb_bridge_clock_and_reset_control.sv
// Self-checking bench for the clock and reset control block.
// Assumes the design files and the board model are compiled first.
`timescale 1ns/10ps
module tb_bridge_clock_and_reset_control;
   import bcrc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err, prst_n = 1'b0, stable = 1'b1, osel_n = 1'b1;
   logic pfast = 1'b0, sfast = 1'b0, strap = 1'b0, ser, ldn, stb, pck, ock;
   logic fast_oe, fout, sec_n, flt, bclr, brdy;
   logic [9:0] soe, sck;
   int bad_count = 0, comparisons = 0, cyc = 0, waits, n, ns;
   always #50 pclk = ~pclk;
   bcrc_board u_board (.pclk(pclk), .load_n(ldn), .strobe(stb), .ser(ser), .pri_clk(pck), .osc_clk(ock));
   bcrc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pri_reset_in_n(prst_n), .sec_clock_stable(stable), .ext_osc_select_n(osel_n),
      .ext_osc_clock(ock), .pri_clock_in(pck), .pri_fast_bus_enable(pfast),
      .sec_fast_bus_enable(sfast), .sec_fast_bus_enable_out(fout), .sec_fast_bus_enable_oe(fast_oe),
      .fast_capable_strap(strap), .mask_serial_in(ser), .mask_shift_load_n(ldn),
      .mask_shift_strobe(stb), .sec_clock_out(sck), .sec_clock_oe(soe), .sec_reset_out_n(sec_n),
      .pri_out_float(flt), .buffer_clear(bclr), .bridge_ready(brdy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wt(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      do begin
         @(posedge pclk);
         waits++;
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic count_rises(output int r);
      logic p;
      r = 0;
      p = sck[0];
      repeat (64) begin
         @(posedge pclk);
         if (sck[0] === 1'b1 && p === 1'b0) begin
            r++;
         end
         p = sck[0];
      end
   endtask
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         summarize;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Pin reset sequence with a mask shift at either rate
   task automatic t_pin(input logic fast);
      pfast <= fast;
      prst_n <= 1'b0;
      wt(10);
      chk("float", 1, flt);
      chk("clear", 1, bclr);
      chk("srst", 0, sec_n);
      chk("load", 0, ldn);
      prst_n <= 1'b1;
      n = 0;
      ns = 0;
      while (sec_n !== 1'b1 && n < 90) begin
         @(posedge pclk);
         n++;
         if (stb === 1'b1) begin
            ns++;
         end
      end
      chk("strobes", 16, ns);
      chk("shift_wait", 1, n > (fast ? 32 : 16));
      chk("release", 1, n >= 43 && n <= 60);
      chk("clear_off", 0, bclr);
      wt(4);
      chk("ready", 1, brdy);
      apb(0, 8'h04, 0);
      chk("mask_rd", 32'h0000FFFF, q);
      chk("oe", 0, soe);
   endtask
   task automatic t_stable;
      stable <= 1'b0;
      prst_n <= 1'b0;
      wt(5);
      prst_n <= 1'b1;
      wt(80);
      chk("unstable", 0, sec_n);
      stable <= 1'b1;
      wt(10);
      chk("stable", 1, sec_n);
   endtask
   task automatic t_swrst;
      apb(1, 8'h00, 32'h1);
      wt(30);
      chk("sw_hold", 0, sec_n);
      apb(1, 8'h00, 32'h0);
      wt(50);
      chk("sw_rel", 1, sec_n);
   endtask
   task automatic t_chip;
      apb(1, 8'h00, 32'h10);
      apb(1, 8'h00, 32'h2);
      chk("chip_srst", 1, sec_n);
      chk("chip_float", 0, flt);
      apb(0, 8'h00, 0);
      chk("chip_busy", 1, waits > 1);
      chk("chip_ctrl", 0, q);
      apb(0, 8'h04, 0);
      chk("chip_mask", 0, q);
   endtask
   task automatic t_pm;
      apb(1, 8'h00, 32'hC);
      apb(1, 8'h00, 32'h0);
      wt(1);
      chk("pm_init", 0, brdy);
      chk("pm_srst", 1, sec_n);
      wt(40);
      chk("pm_ready", 1, brdy);
   endtask
   task automatic t_div;
      for (int i = 0; i < 8; i++) begin
         {osel_n, pfast, sfast} <= 3'(i);
         wt(8);
         apb(0, 8'h08, 0);
         chk("div", 32'(i[1] & ~i[0]), 32'(q[4]));
         chk("fast_oe", 32'(~i[1] & 1'b1), 32'(fast_oe));
         chk("fast_out", 0, fout);
         count_rises(n);
         chk("clk_rate", (i[2] ? 16 : 8) >> (i[1] & ~i[0]), n);
         chk("clk_all", {22'h0, {10{sck[0]}}}, {22'h0, sck});
      end
      apb(1, 8'h00, 32'h10);
      {pfast, sfast} <= 2'b10;
      wt(8);
      apb(0, 8'h08, 0);
      chk("direct", 0, 32'(q[4]));
      count_rises(n);
      chk("direct_rate", 16, n);
      apb(0, 8'h0C, 0);
      chk("unmapped", 32'h1, {31'h0, err});
      chk("unmapped_rd", 0, q);
      for (int s = 0; s < 2; s++) begin
         strap <= 1'(s);
         wt(8);
         apb(0, 8'h08, 0);
         chk("strap", 32'(s * 3), 32'(q[1:0]));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      wt(3);
      presetn <= 1'b1;
      wt(1);
      apb(0, 8'h00, 0);
      chk("ctrl_rst", 0, q);
      t_pin(1'b0);
      t_pin(1'b1);
      t_stable;
      t_swrst;
      t_chip;
      t_pm;
      t_div;
      summarize;
   end
endmodule
